// ===== inc/pdwr_pkg.sv
// package: constants and types for the power-down / wake-up / io block
package pdwr_pkg;
    localparam int          PDWR_PINS       = 8;
    localparam int          PDWR_AW         = 3;
    // register offsets
    localparam logic [2:0]  PDWR_A_DATA     = 3'h0;
    localparam logic [2:0]  PDWR_A_DIR      = 3'h1;
    localparam logic [2:0]  PDWR_A_PULL     = 3'h2;
    localparam logic [2:0]  PDWR_A_WAKE_EN  = 3'h3;
    localparam logic [2:0]  PDWR_A_MISC     = 3'h4;
    localparam logic [2:0]  PDWR_A_CMD      = 3'h5;
    localparam logic [2:0]  PDWR_A_STATUS   = 3'h6;
    // field positions
    localparam int          PDWR_MISC_FAST  = 0;
    localparam int          PDWR_CMD_EXE    = 0;
    localparam int          PDWR_CMD_SYS    = 1;
    localparam int          PDWR_ODR_PIN    = 5;
    localparam int          PDWR_EXTI_PIN   = 0;
    // reset values
    localparam logic [7:0]  PDWR_RST_DATA   = 8'h00;
    localparam logic [7:0]  PDWR_RST_DIR    = 8'h00;
    localparam logic [7:0]  PDWR_RST_PULL   = 8'h00;
    localparam logic [7:0]  PDWR_RST_WAKE   = 8'h00;
    localparam logic [7:0]  PDWR_RST_MISC   = 8'h00;
    // wake delays in low-speed oscillator periods
    localparam int          PDWR_SLOW_WAKE  = 2048;
    localparam int          PDWR_FAST_WAKE  = 32;
    localparam int          PDWR_CNT_W      = 12;
    // low-speed oscillator tick: divider of the 10 MHz system clock
    localparam int          PDWR_CLK_HZ     = 10000000;
    localparam int          PDWR_LS_HZ      = 1000000;
    localparam int          PDWR_LS_DIV     = PDWR_CLK_HZ / PDWR_LS_HZ;

    typedef enum logic [3:0] {
        PDWR_ST_RUN  = 4'b0001,
        PDWR_ST_EXE  = 4'b0010,
        PDWR_ST_SYS  = 4'b0100,
        PDWR_ST_WAKE = 4'b1000
    } pdwr_state_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull;
    } pdwr_pad_type;

    typedef struct packed {
        logic       hs_osc_en;
        logic       ls_osc_en;
        logic       sys_clk_en;
        logic       prog_mem_en;
    } pdwr_pwr_type;
endpackage

// ===== testbench/pdwr_pins_model.sv
// board-side pin model: resolves each pad level from all drivers
`timescale 1ns/100ps
module pdwr_pins_model
    import pdwr_pkg::*;
(
    // clock
    input  wire logic         clk_sys_i,
    // device side
    input  wire pdwr_pad_type pad_o_i,
    // board side
    input  wire logic [7:0]   ext_en_i,
    input  wire logic [7:0]   ext_val_i,
    output logic      [7:0]   pad_lvl_o
);
    logic [7:0] flt = 8'h55;

    // undriven, unpulled pins wander so a stale level is never trusted
    always_ff @(posedge clk_sys_i)
        flt <= ~flt;

    // device drive wins, then board drive, then pull-up, else wander
    assign pad_lvl_o = (~pad_o_i.oe_n & pad_o_i.out)
                     | (pad_o_i.oe_n & ext_en_i & ext_val_i)
                     | (pad_o_i.oe_n & ~ext_en_i & (pad_o_i.pull | flt));
endmodule // pdwr_pins_model

// ===== testbench/pdwr_top_tb_top.sv
// self-checking bench for the power-down, wake-up and pin block
`timescale 1ns/100ps
module pdwr_top_tb_top;
    import pdwr_pkg::*;
    localparam int LS  = 1;
    localparam int TMO = 10000;

    logic               clk         = 1'b0;
    logic               arst_n      = 1'b0;
    logic [PDWR_AW-1:0] addr        = '0;
    logic [7:0]         wdata       = 8'h00;
    logic               wr          = 1'b0;
    logic               rd          = 1'b0;
    logic               timer_match = 1'b0;
    logic               ext_rst     = 1'b0;
    logic               wdt_rst     = 1'b0;
    logic [7:0]         ext_en      = 8'hFF;
    logic [7:0]         ext_val     = 8'hA5;
    logic [7:0]         rdata;
    logic [7:0]         pad_lvl;
    pdwr_pad_type       pad;
    pdwr_pwr_type       pwr;
    logic               mem_retain;
    int                 error_cnt   = 0;
    int                 num_checks  = 0;
    int                 cyc         = 0;

    always #50 clk = ~clk;

    pdwr_top #(.LS_DIV(LS)) i_pdwr_top (
        .clk_sys_i     (clk),
        .arst_n_i      (arst_n),
        .addr_i        (addr),
        .wdata_i       (wdata),
        .wr_i          (wr),
        .rd_i          (rd),
        .rdata_o       (rdata),
        .pad_i         (pad_lvl),
        .pad_o         (pad),
        .timer_match_i (timer_match),
        .ext_reset_i   (ext_rst),
        .wdt_reset_i   (wdt_rst),
        .pwr_o         (pwr),
        .mem_retain_o  (mem_retain)
    );

    pdwr_pins_model i_pdwr_pins_model (
        .clk_sys_i (clk),
        .pad_o_i   (pad),
        .ext_en_i  (ext_en),
        .ext_val_i (ext_val),
        .pad_lvl_o (pad_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == TMO)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        if (seen !== exp)
            error_cnt++;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // counts cycles until the system clock comes back
    task automatic wait_wake(input int lo, input int hi);
        int n;
        n = 0;
        while (pwr.sys_clk_en !== 1'b1 && n <= hi)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(PDWR_A_DATA, 8'hFF, 8'hA5);
        rd_chk(PDWR_A_DIR, 8'hFF, PDWR_RST_DIR);
        rd_chk(PDWR_A_PULL, 8'hFF, PDWR_RST_PULL);
        rd_chk(PDWR_A_WAKE_EN, 8'hFF, PDWR_RST_WAKE);
        rd_chk(PDWR_A_MISC, 8'hFF, PDWR_RST_MISC);
        rd_chk(PDWR_A_STATUS, 8'hFF, 8'h11);
        rd_chk(3'h7, 8'hFF, 8'h00);
        chk(8'(pwr), 8'h0F);
        chk(pad.oe_n, 8'hFF);
        chk(pad.pull, 8'h00);
        chk(pad.out, 8'h00);
    endtask

    task automatic t_io;
        ext_en <= 8'hF0;
        ext_val <= 8'hA0;
        wr_reg(PDWR_A_DIR, 8'h0F);
        wr_reg(PDWR_A_DATA, 8'h35);
        wr_reg(PDWR_A_PULL, 8'hFF);
        settle();
        chk(pad.oe_n, 8'hF0);
        chk(pad.out & ~pad.oe_n, 8'h05);
        chk(pad.pull, 8'hF5);
        wr_reg(PDWR_A_PULL, 8'h0F);
        settle();
        chk(pad.pull, 8'h05);
        rd_chk(PDWR_A_DATA, 8'hFF, 8'hA5);
        // open-drain pin: high means float, so the pad wanders
        ext_en <= 8'h00;
        wr_reg(PDWR_A_DIR, 8'h20);
        wr_reg(PDWR_A_DATA, 8'h20);
        settle();
        chk(8'(pad.oe_n[PDWR_ODR_PIN]), 8'h01);
        chk(8'(pad.out[PDWR_ODR_PIN]), 8'h00);
        rd_chk(PDWR_A_DATA, 8'h20, 8'h20);
        wr_reg(PDWR_A_DATA, 8'h00);
        settle();
        chk(8'(pad.oe_n[PDWR_ODR_PIN]), 8'h00);
    endtask

    task automatic t_deep;
        ext_en <= 8'hFF;
        ext_val <= 8'h00;
        wr_reg(PDWR_A_DIR, 8'h00);
        wr_reg(PDWR_A_WAKE_EN, 8'h01);
        wr_reg(PDWR_A_MISC, 8'h01);
        settle();
        wr_reg(PDWR_A_CMD, 8'h02);
        settle();
        chk(8'(pwr), 8'h00);
        // toggle on a pin without wake enable, and a timer match
        @(posedge clk);
        ext_val <= 8'h08;
        timer_match <= 1'b1;
        repeat (60) @(posedge clk);
        #1 chk(8'(pwr), 8'h00);
        @(posedge clk);
        timer_match <= 1'b0;
        ext_val <= 8'h09;
        repeat (6) @(posedge clk);
        #1 chk(8'(pwr), 8'h04);
        wait_wake(32 * LS - 6, 32 * LS + 8);
        chk(8'(pwr), 8'h0F);
        rd_chk(PDWR_A_WAKE_EN, 8'hFF, 8'h01);
        rd_chk(PDWR_A_MISC, 8'hFF, 8'h01);
        rd_chk(PDWR_A_STATUS, 8'h0F, 8'h01);
    endtask

    task automatic t_light;
        wr_reg(PDWR_A_MISC, 8'h00);
        wr_reg(PDWR_A_CMD, 8'h01);
        settle();
        chk(8'(pwr), 8'h0C);
        @(posedge clk);
        timer_match <= 1'b1;
        wait_wake(2048 * LS - 6, 2048 * LS + 8);
        chk(8'(pwr), 8'h0F);
        @(posedge clk);
        timer_match <= 1'b0;
        rd_chk(PDWR_A_STATUS, 8'h0F, 8'h01);
    endtask

    task automatic t_rst;
        @(posedge clk);
        ext_rst <= 1'b1;
        settle();
        chk(8'(mem_retain), 8'h01);
        @(posedge clk);
        ext_rst <= 1'b0;
        wdt_rst <= 1'b1;
        settle();
        chk(8'(mem_retain), 8'h01);
        @(posedge clk);
        wdt_rst <= 1'b0;
        settle();
        chk(8'(mem_retain), 8'h00);
        wr_reg(PDWR_A_PULL, 8'h3C);
        wr_reg(PDWR_A_DIR, 8'h3C);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(PDWR_A_PULL, 8'hFF, PDWR_RST_PULL);
        rd_chk(PDWR_A_DIR, 8'hFF, PDWR_RST_DIR);
        rd_chk(PDWR_A_WAKE_EN, 8'hFF, PDWR_RST_WAKE);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_io();
        t_deep();
        t_light();
        t_rst();
        test_done();
    end
endmodule // pdwr_top_tb_top

// ===== verilog/pdwr_ls_tick.sv
// low-speed oscillator model: one-cycle tick from a divider, gated by enable
`timescale 1ns/100ps
module pdwr_ls_tick
    import pdwr_pkg::*;
#(
    parameter int DIV = PDWR_LS_DIV
)(
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic run_i,
    output logic      tick_o
);
    logic [15:0] cnt;

    // counter is 16 bits wide, so larger dividers cannot be served
    if (DIV < 1 || DIV > 65535)
    begin : g_bad_div
        $error("pdwr_ls_tick: DIV out of range");
    end

    // a stopped oscillator restarts from zero phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt    <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt    <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (cnt == 16'(DIV - 1))
        begin
            cnt    <= 16'h0000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt    <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule // pdwr_ls_tick

// ===== verilog/pdwr_sync.sv
// two-flop synchroniser for pad levels
`timescale 1ns/100ps
module pdwr_sync
    import pdwr_pkg::*;
#(
    parameter int WIDTH = 8
)(
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // refused at elaboration, not at run time
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pdwr_sync: WIDTH must be positive");
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // pdwr_sync

// ===== verilog/pdwr_top.sv
// power-down, wake-up sequencing and port pin control
// Operation
// - deep power-down stops both oscillators at once
// - deep power-down cuts program memory, keeps state
// - deep power-down wakes only on enabled pin toggle
// - pin wake resumes after suspend, no reset
// - timer wake only in light power-save
// - slow wake waits 2048 low-speed periods
// - fast wake option waits 32 low-speed periods
// - input pin pull-up follows pull-up bit
// - output pin drives data, pull-up if bit
// - output low always drops pull-up
// - data read gives latch or pad level
// - reset-capable pin drives only low, open-drain
// - any reset loads defaults and restarts; only arst_n_i does so, ext_reset_i/wdt_reset_i just drive mem_retain_o
// - data memory kept over pin/watchdog reset
// - light power-save gates system clock and program memory
// - light power-save wakes on timer match
`timescale 1ns/100ps
module pdwr_top
    import pdwr_pkg::*;
#(
    parameter int LS_DIV = PDWR_LS_DIV
)(
    // clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 arst_n_i,
    // register port
    input  wire logic [PDWR_AW-1:0]   addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    // pads
    input  wire logic [PDWR_PINS-1:0] pad_i,
    output pdwr_pad_type              pad_o,
    // wake sources and reset cause
    input  wire logic                 timer_match_i,
    input  wire logic                 ext_reset_i,
    input  wire logic                 wdt_reset_i,
    // power control
    output pdwr_pwr_type              pwr_o,
    output logic                      mem_retain_o
);
    ////////////////////////////////////////////////////////////////////
    logic           rst_s1;
    logic           rst_n;
    logic [7:0]     pad_s;
    logic [7:0]     data_latch;
    logic [7:0]     dir;
    logic [7:0]     pull;
    logic [7:0]     wake_en;
    logic [7:0]     misc;
    logic [7:0]     entry_lvl;
    logic [11:0]    wcnt;
    logic           ls_tick;
    logic           was_sys;
    logic           rst_seen;
    pdwr_state_type state;
    pdwr_state_type next_state;

    // reset release: two flops, everything else uses rst_n
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    pdwr_sync #(.WIDTH(PDWR_PINS)) u_pad_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .async_i   (pad_i),
        .sync_o    (pad_s)
    );

    ////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_data = wr_i && addr_i == PDWR_A_DATA;
    wire wr_dir  = wr_i && addr_i == PDWR_A_DIR;
    wire wr_pull = wr_i && addr_i == PDWR_A_PULL;
    wire wr_wake = wr_i && addr_i == PDWR_A_WAKE_EN;
    wire wr_misc = wr_i && addr_i == PDWR_A_MISC;
    wire wr_cmd  = wr_i && addr_i == PDWR_A_CMD;
    wire cmd_sys = wr_cmd && wdata_i[PDWR_CMD_SYS];
    wire cmd_exe = wr_cmd && wdata_i[PDWR_CMD_EXE] && !cmd_sys;
    wire fast    = misc[PDWR_MISC_FAST];

    // latch for outputs, pad for inputs
    wire [7:0] data_view = (dir & data_latch) | (~dir & pad_s);
    wire [7:0] status_v  = {3'h0, rst_seen, state};
    wire [7:0] rd_mux =
        (addr_i == PDWR_A_DATA)    ? data_view :
        (addr_i == PDWR_A_DIR)     ? dir       :
        (addr_i == PDWR_A_PULL)    ? pull      :
        (addr_i == PDWR_A_WAKE_EN) ? wake_en   :
        (addr_i == PDWR_A_MISC)    ? misc      :
        (addr_i == PDWR_A_STATUS)  ? status_v  : 8'h00;

    // registers take defaults on every arst_n_i reset, not on ext_reset_i or wdt_reset_i
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_latch <= PDWR_RST_DATA;
            dir        <= PDWR_RST_DIR;
            pull       <= PDWR_RST_PULL;
            wake_en    <= PDWR_RST_WAKE;
            misc       <= PDWR_RST_MISC;
            rdata_o    <= 8'h00;
        end
        else
        begin
            if (wr_data) data_latch <= wdata_i;
            if (wr_dir)  dir        <= wdata_i;
            if (wr_pull) pull       <= wdata_i;
            if (wr_wake) wake_en    <= wdata_i;
            if (wr_misc) misc       <= wdata_i;
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pad drive
    wire [7:0] drv_hi  = dir & data_latch;
    wire [7:0] drv_lo  = dir & ~data_latch;
    // pull-up on per bit, but never while driving low
    wire [7:0] pull_on = pull & ~drv_lo;
    // open-drain pin never drives high
    wire [7:0] od_mask = 8'(1) << PDWR_ODR_PIN;
    wire [7:0] oe_n_v  = ~((dir & ~od_mask) | (drv_lo & od_mask));
    wire [7:0] out_v   = drv_hi & ~od_mask;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            pad_o <= '{out: 8'h00, oe_n: 8'hFF, pull: 8'h00};
        else
            pad_o <= '{out: out_v, oe_n: oe_n_v, pull: pull_on};
    end

    ////////////////////////////////////////////////////////////////////
    // wake detection and sequencing
    wire toggle  = |((pad_s ^ entry_lvl) & wake_en & ~dir);
    wire t_wake  = timer_match_i && state == PDWR_ST_EXE;
    wire [11:0] wlen = fast ? 12'(PDWR_FAST_WAKE - 1)
                            : 12'(PDWR_SLOW_WAKE - 1);
    wire ls_run  = state != PDWR_ST_SYS;

    pdwr_ls_tick #(.DIV(LS_DIV)) u_ls (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .run_i     (ls_run),
        .tick_o    (ls_tick)
    );

    always_comb
    begin
        next_state = state;
        unique case (state)
            PDWR_ST_RUN:
                if (cmd_sys)
                    next_state = PDWR_ST_SYS;
                else if (cmd_exe)
                    next_state = PDWR_ST_EXE;
            PDWR_ST_EXE:
                if (toggle || t_wake)
                    next_state = PDWR_ST_WAKE;
            PDWR_ST_SYS:
                if (toggle)
                    next_state = PDWR_ST_WAKE;
            PDWR_ST_WAKE:
                if (ls_tick && wcnt == wlen)
                    next_state = PDWR_ST_RUN;
            default:
                next_state = PDWR_ST_RUN;
        endcase
    end

    // entry level sampled on the command so toggles compare against it
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= PDWR_ST_RUN;
            entry_lvl <= 8'h00;
            wcnt      <= 12'h000;
            was_sys   <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == PDWR_ST_RUN)
            begin
                entry_lvl <= pad_s;
                was_sys   <= cmd_sys;
            end
            if (state != PDWR_ST_WAKE)
                wcnt <= 12'h000;
            else if (ls_tick)
                wcnt <= wcnt + 12'h001;
        end
    end

    // power outputs: suspend never touches register contents
    wire sys_clk_v = state == PDWR_ST_RUN;
    wire hs_v = !(state == PDWR_ST_SYS ||
                 (state == PDWR_ST_WAKE && was_sys));
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_o        <= '{1'b1, 1'b1, 1'b1, 1'b1};
            mem_retain_o <= 1'b0;
            rst_seen     <= 1'b0;
        end
        else
        begin
            pwr_o.hs_osc_en   <= hs_v;
            pwr_o.ls_osc_en   <= ls_run;
            pwr_o.sys_clk_en  <= sys_clk_v;
            pwr_o.prog_mem_en <= sys_clk_v;
            // memory kept only for pin/watchdog causes, follows their levels
            mem_retain_o <= ext_reset_i || wdt_reset_i;
            rst_seen     <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_sys_stop;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_SYS |=> !pwr_o.hs_osc_en && !pwr_o.ls_osc_en;
    endproperty
    a_sys_stop: assert property (p_sys_stop)
        else $error("oscillator running in deep power-down");

    property p_mem_off;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state != PDWR_ST_RUN |=> !pwr_o.prog_mem_en;
    endproperty
    a_mem_off: assert property (p_mem_off)
        else $error("program memory on during suspend");

    property p_sys_wake;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_SYS && next_state == PDWR_ST_WAKE |-> toggle;
    endproperty
    a_sys_wake: assert property (p_sys_wake)
        else $error("deep power-down left without toggle");

    property p_regs_kept;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_WAKE && next_state == PDWR_ST_RUN
            |=> $stable(dir) || $past(wr_dir);
    endproperty
    a_regs_kept: assert property (p_regs_kept)
        else $error("registers disturbed by wake");

    property p_no_tmr;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_SYS && timer_match_i && !toggle |=>
            state == PDWR_ST_SYS;
    endproperty
    a_no_tmr: assert property (p_no_tmr)
        else $error("timer woke deep power-down");

    property p_wake_len;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_WAKE && next_state == PDWR_ST_RUN |->
            wcnt == (fast ? 12'h01F : 12'h7FF);
    endproperty
    a_wake_len: assert property (p_wake_len)
        else $error("wake delay length wrong");

    property p_pull_low;
        @(posedge clk_sys_i) disable iff (!rst_n)
        1'b1 |=> (pad_o.pull & $past(drv_lo)) == 8'h00;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("pull-up on while driving low");

    property p_od;
        @(posedge clk_sys_i) disable iff (!rst_n)
        1'b1 |=> !pad_o.out[PDWR_ODR_PIN];
    endproperty
    a_od: assert property (p_od)
        else $error("open-drain pin driven high");

    property p_clk_gate;
        @(posedge clk_sys_i) disable iff (!rst_n)
        state == PDWR_ST_EXE |=> !pwr_o.sys_clk_en && pwr_o.ls_osc_en;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("light power-save gating wrong");

    // deep wake: low-speed oscillator back first, fast one and cpu later
    sequence s_sys_to_wake;
        state == PDWR_ST_SYS ##1 state == PDWR_ST_WAKE;
    endsequence

    property p_deep_ls_first;
        @(posedge clk_sys_i) disable iff (!rst_n)
        s_sys_to_wake |=> pwr_o.ls_osc_en && !pwr_o.hs_osc_en &&
            !pwr_o.sys_clk_en;
    endproperty
    a_deep_ls_first: assert property (p_deep_ls_first)
        else $error("deep wake restart order wrong");
endmodule // pdwr_top
